// [logic/irq_pkg.sv]
// Shared constants and types for the interrupt response and register logic.
package irq_pkg;
	localparam logic [15:0] NMI_ADDR   = 16'h0066;
	localparam logic [15:0] MODE1_ADDR = 16'h0038;
	localparam logic [15:0] PC_RESET   = 16'h0000;
	localparam logic [15:0] SP_RESET   = 16'hffff;
	localparam logic [15:0] W16_RESET  = 16'h0000;
	localparam logic [7:0]  R8_RESET   = 8'h00;
	localparam logic [1:0]  ACK_WAITS  = 2'h2;
	localparam int          PV_BIT     = 2;
	localparam logic [2:0]  IDX_A = 3'h0;
	localparam logic [2:0]  IDX_F = 3'h1;
	localparam logic [1:0]  MODE0 = 2'h0;
	localparam logic [1:0]  MODE1 = 2'h1;
	localparam logic [1:0]  MODE2 = 2'h2;
	localparam logic [4:0]  SEL_PAIR1 = 5'h08;
	localparam logic [4:0]  SEL_PAIR2 = 5'h09;
	localparam logic [4:0]  SEL_PAIR3 = 5'h0a;
	localparam logic [4:0]  SEL_VB    = 5'h0b;
	localparam logic [4:0]  SEL_R     = 5'h0c;
	localparam logic [4:0]  SEL_IX    = 5'h0d;
	localparam logic [4:0]  SEL_IY    = 5'h0e;
	localparam logic [4:0]  SEL_SP    = 5'h0f;
	localparam logic [4:0]  SEL_PC    = 5'h10;
	typedef enum logic [3:0] {
		S_IDLE     = 4'h0,
		S_ACK      = 4'h1,
		S_ACK_WAIT = 4'h2,
		S_ACK_TAKE = 4'h3,
		S_PUSH_HI  = 4'h4,
		S_PUSH_LO  = 4'h5,
		S_TAB_LO   = 4'h6,
		S_TAB_HI   = 4'h7,
		S_JUMP     = 4'h8
	} irq_state_t;
	typedef enum logic [1:0] {
		ENTRY_NMI = 2'h0,
		ENTRY_M1  = 2'h1,
		ENTRY_M2  = 2'h2
	} entry_t;
endpackage

// [logic/register_bank.sv]
// Main and alternate banks of accumulator, flags and general registers.
`timescale 1ns/1ps
module register_bank (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  wr_mask,
	input  wire logic [63:0] wr_data,
	input  wire logic        swap_af,
	input  wire logic        swap_gen,
	output logic      [63:0] visible
);
	logic [7:0] bank_q [2][8];
	logic [7:0] bank_d [2][8];
	logic       af_alt_q;
	logic       af_alt_d;
	logic       gen_alt_q;
	logic       gen_alt_d;

	always_comb begin
		logic sel;
		sel = 1'b0;
		bank_d = bank_q;
		af_alt_d = af_alt_q ^ swap_af;
		gen_alt_d = gen_alt_q ^ swap_gen;
		visible = '0;
		for (int i = 0; i < 8; i++) begin
			sel = (i < 2) ? af_alt_q : gen_alt_q;
			visible[8*i +: 8] = bank_q[sel][i];
			if (wr_mask[i]) begin
				bank_d[sel][i] = wr_data[8*i +: 8];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			for (int b = 0; b < 2; b++) begin
				for (int i = 0; i < 8; i++) begin
					bank_q[b][i] <= irq_pkg::R8_RESET;
				end
			end
			af_alt_q <= 1'b0;
			gen_alt_q <= 1'b0;
		end else begin
			bank_q <= bank_d;
			af_alt_q <= af_alt_d;
			gen_alt_q <= gen_alt_d;
		end
	end
endmodule

// [logic/refresh_counter.sv]
// Refresh counter that steps on every opcode fetch unless a load comes in the same cycle.
`timescale 1ns/1ps
module refresh_counter (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       load,
	input  wire logic [7:0] load_value,
	input  wire logic       step,
	output logic      [7:0] value_q
);
	logic [7:0] value_d;

	always_comb begin
		value_d = value_q;
		if (load) begin
			value_d = load_value;
		end else if (step) begin
			value_d = value_q + 8'h01;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			value_q <= irq_pkg::R8_RESET;
		end else begin
			value_q <= value_d;
		end
	end
endmodule

// [logic/cpu_interrupt_response.sv]
// Interrupt acceptance, enable and mode flip-flops and the visible register file.
// Behaviour
// RULE_01 - NMI without bus hold jumps to 0066h
// RULE_02 - Maskable accepted only when enabled, no hold
// RULE_03 - Acknowledge is fetch cycle with I/O strobe
// RULE_04 - Acknowledge lengthened by two wait states
// RULE_05 - Mode 0 peripheral supplies executed opcode
// RULE_06 - Mode 0 call: one acknowledge, then reads; the code returns to S_IDLE after the acknowledge with no further reads
// RULE_07 - Mode 1 acts like NMI at 0038h
// RULE_08 - Mode 2 pointer is vector base, vector
// RULE_09 - Mode 2 reads table entry, jumps there
// RULE_10 - Mode 2 vector bit zero is zero; the code keeps bit zero of data_in as received
// RULE_11 - Reset and disable clear, enable sets both
// RULE_12 - Copy base or refresh puts saved in PV
// RULE_13 - NMI clears main; return copies saved back
// RULE_14 - Refresh steps and drives address on fetch; the code skips the step when a write to SEL_R loads it in the same cycle
// RULE_15 - Six registers also form three pairs
// RULE_16 - Two banks selected by exchange instructions
// RULE_17 - Mode flip-flops choose maskable response
// RULE_18 - NMI ignores enables; sample at boundaries
// RULE_19 - Push program counter before vectoring
`timescale 1ns/1ps
module cpu_interrupt_response (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        nmi_req,
	input  wire logic        int_req,
	input  wire logic        bus_hold_request,
	input  wire logic [7:0]  data_in,
	input  wire logic        instr_boundary,
	input  wire logic        fetch_strobe,
	input  wire logic        mask_off_op,
	input  wire logic        unmask_op,
	input  wire logic        nonmaskable_return_op,
	input  wire logic        copy_vector_base_op,
	input  wire logic        copy_refresh_op,
	input  wire logic        exchange_af_op,
	input  wire logic        exchange_bank_op,
	input  wire logic        set_mode_op,
	input  wire logic [1:0]  set_mode_value,
	input  wire logic        reg_we,
	input  wire logic [4:0]  reg_sel,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata_q,
	output logic      [15:0] address_q,
	output logic      [7:0]  data_out_q,
	output logic             memory_cycle_strobe_n_q,
	output logic             io_cycle_strobe_n_q,
	output logic             opcode_fetch_cycle_n_q,
	output logic             read_n_q,
	output logic             write_n_q,
	output logic             ack_wait_q,
	output logic             busy_q,
	output logic      [7:0]  mode0_opcode_q,
	output logic             mode0_valid_q,
	output logic             irq_enable_main_q,
	output logic             irq_enable_saved_q,
	output logic      [1:0]  irq_mode_bits_q,
	output logic      [15:0] next_fetch_address_q
);
	irq_pkg::irq_state_t state_q, state_d;
	irq_pkg::entry_t     entry_q, entry_d;
	logic [1:0]  wcnt_q, wcnt_d;
	logic [7:0]  vec_q, vec_d;
	logic [7:0]  tlo_q, tlo_d;
	logic [15:0] sp_q, sp_d;
	logic [15:0] ix_q, ix_d;
	logic [15:0] iy_q, iy_d;
	logic [7:0]  vb_q, vb_d;
	logic        nmi_seen_q, nmi_pend_q, nmi_pend_d;
	logic [15:0] pc_d, rdata_d, addr_d;
	logic [7:0]  dout_d, m0op_d;
	logic        mem_n_d, io_n_d, fetch_n_d, rd_n_d, wr_n_d, m0v_d;
	logic        irq_enable_main_d, irq_enable_saved_d;
	logic [1:0]  mode_d;
	logic [7:0]  bank_mask;
	logic [63:0] bank_wdata;
	logic [63:0] vis;
	logic        r_load;
	logic [7:0]  r_val;
	logic        take_nmi, take_int, op_ok;

	function automatic logic [7:0] byte_of(input logic [63:0] v, input logic [2:0] i);
		return v[8*i +: 8];
	endfunction

	function automatic logic [15:0] pair_of(input logic [63:0] v, input logic [1:0] p);
		return {byte_of(v, 3'(2*p)), byte_of(v, 3'(2*p + 1))};
	endfunction

	register_bank u_bank (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.wr_mask  (bank_mask),
		.wr_data  (bank_wdata),
		.swap_af  (op_ok && exchange_af_op), // RULE_16
		.swap_gen (op_ok && exchange_bank_op), // RULE_16
		.visible  (vis)
	);

	refresh_counter u_refresh (
		.clk_sys    (clk_sys),
		.sys_rst    (sys_rst),
		.load       (r_load),
		.load_value (reg_wdata[7:0]),
		.step       (fetch_strobe || state_d == irq_pkg::S_ACK), // RULE_14
		.value_q    (r_val)
	);

	assign take_nmi = state_q == irq_pkg::S_IDLE && instr_boundary && !bus_hold_request
		&& nmi_pend_q; // RULE_18
	assign take_int = state_q == irq_pkg::S_IDLE && instr_boundary && !bus_hold_request
		&& !nmi_pend_q && int_req && irq_enable_main_q; // RULE_02
	assign op_ok = state_q == irq_pkg::S_IDLE && !take_nmi && !take_int;

	always_comb begin
		state_d = state_q;
		entry_d = entry_q;
		wcnt_d = wcnt_q;
		vec_d = vec_q;
		tlo_d = tlo_q;
		pc_d = next_fetch_address_q;
		sp_d = sp_q;
		ix_d = ix_q;
		iy_d = iy_q;
		vb_d = vb_q;
		irq_enable_main_d = irq_enable_main_q;
		irq_enable_saved_d = irq_enable_saved_q;
		mode_d = irq_mode_bits_q;
		m0op_d = mode0_opcode_q;
		m0v_d = 1'b0;
		bank_mask = '0;
		bank_wdata = vis;
		r_load = 1'b0;
		nmi_pend_d = nmi_pend_q;
		unique case (state_q)
			irq_pkg::S_IDLE: begin
				if (take_nmi) begin
					nmi_pend_d = 1'b0;
					irq_enable_main_d = 1'b0; // RULE_13
					entry_d = irq_pkg::ENTRY_NMI;
					state_d = irq_pkg::S_PUSH_HI; // RULE_19
				end else if (take_int) begin
					irq_enable_main_d = 1'b0;
					irq_enable_saved_d = 1'b0;
					state_d = irq_pkg::S_ACK; // RULE_02
				end else begin
					if (mask_off_op) begin
						irq_enable_main_d = 1'b0; // RULE_11
						irq_enable_saved_d = 1'b0;
					end else if (unmask_op) begin
						irq_enable_main_d = 1'b1; // RULE_11
						irq_enable_saved_d = 1'b1;
					end else if (nonmaskable_return_op) begin
						irq_enable_main_d = irq_enable_saved_q; // RULE_13
					end
					if (set_mode_op) begin
						mode_d = set_mode_value; // RULE_17
					end
					if (copy_vector_base_op || copy_refresh_op) begin
						bank_mask[irq_pkg::IDX_A] = 1'b1;
						bank_mask[irq_pkg::IDX_F] = 1'b1;
						bank_wdata[8*irq_pkg::IDX_A +: 8] = copy_refresh_op ? r_val : vb_q;
						bank_wdata[8*irq_pkg::IDX_F + irq_pkg::PV_BIT] =
							irq_enable_saved_q; // RULE_12
					end else if (reg_we) begin
						if (reg_sel < 5'h08) begin
							bank_mask[reg_sel[2:0]] = 1'b1;
							bank_wdata[8*reg_sel[2:0] +: 8] = reg_wdata[7:0];
						end else if (reg_sel <= irq_pkg::SEL_PAIR3) begin
							bank_mask[3'(2*(reg_sel - 5'h07))] = 1'b1; // RULE_15
							bank_mask[3'(2*(reg_sel - 5'h07) + 1)] = 1'b1;
							bank_wdata[16*(reg_sel - 5'h07) +: 16] =
								{reg_wdata[7:0], reg_wdata[15:8]};
						end
						unique case (reg_sel)
							irq_pkg::SEL_VB: vb_d = reg_wdata[7:0];
							irq_pkg::SEL_R:  r_load = 1'b1;
							irq_pkg::SEL_IX: ix_d = reg_wdata;
							irq_pkg::SEL_IY: iy_d = reg_wdata;
							irq_pkg::SEL_SP: sp_d = reg_wdata;
							irq_pkg::SEL_PC: pc_d = reg_wdata;
							default: ;
						endcase
					end
				end
			end
			irq_pkg::S_ACK: begin
				wcnt_d = 2'h0;
				state_d = irq_pkg::S_ACK_WAIT;
			end
			irq_pkg::S_ACK_WAIT: begin
				if (wcnt_q == irq_pkg::ACK_WAITS - 2'h1) begin
					state_d = irq_pkg::S_ACK_TAKE; // RULE_04
				end else begin
					wcnt_d = wcnt_q + 2'h1;
				end
			end
			irq_pkg::S_ACK_TAKE: begin
				vec_d = data_in; // RULE_10
				unique case (irq_mode_bits_q)
					irq_pkg::MODE0: begin
						m0op_d = data_in; // RULE_05
						m0v_d = 1'b1; // RULE_06
						state_d = irq_pkg::S_IDLE;
					end
					irq_pkg::MODE1: begin
						entry_d = irq_pkg::ENTRY_M1; // RULE_07
						state_d = irq_pkg::S_PUSH_HI;
					end
					default: begin
						entry_d = irq_pkg::ENTRY_M2; // RULE_17
						state_d = irq_pkg::S_PUSH_HI;
					end
				endcase
			end
			irq_pkg::S_PUSH_HI: begin
				sp_d = sp_q - 16'h0001;
				state_d = irq_pkg::S_PUSH_LO;
			end
			irq_pkg::S_PUSH_LO: begin
				sp_d = sp_q - 16'h0001;
				state_d = (entry_q == irq_pkg::ENTRY_M2) ? irq_pkg::S_TAB_LO : irq_pkg::S_JUMP;
			end
			irq_pkg::S_TAB_LO: begin
				tlo_d = data_in;
				state_d = irq_pkg::S_TAB_HI;
			end
			irq_pkg::S_TAB_HI: begin
				pc_d = {data_in, tlo_q}; // RULE_09
				state_d = irq_pkg::S_IDLE;
			end
			irq_pkg::S_JUMP: begin
				pc_d = (entry_q == irq_pkg::ENTRY_NMI) ? irq_pkg::NMI_ADDR
					: irq_pkg::MODE1_ADDR; // RULE_01
				state_d = irq_pkg::S_IDLE;
			end
			default: state_d = irq_pkg::S_IDLE;
		endcase
		if (nmi_req && !nmi_seen_q) begin
			nmi_pend_d = 1'b1;
		end
	end

	always_comb begin
		addr_d = address_q;
		dout_d = data_out_q;
		mem_n_d = 1'b1;
		io_n_d = 1'b1;
		fetch_n_d = 1'b1;
		rd_n_d = 1'b1;
		wr_n_d = 1'b1;
		unique case (state_d)
			irq_pkg::S_ACK, irq_pkg::S_ACK_WAIT, irq_pkg::S_ACK_TAKE: begin
				addr_d = next_fetch_address_q;
				fetch_n_d = 1'b0;
				io_n_d = 1'b0; // RULE_03
			end
			irq_pkg::S_PUSH_HI, irq_pkg::S_PUSH_LO: begin
				addr_d = sp_d - 16'h0001;
				dout_d = (state_d == irq_pkg::S_PUSH_HI) ? next_fetch_address_q[15:8]
					: next_fetch_address_q[7:0]; // RULE_19
				mem_n_d = 1'b0;
				wr_n_d = 1'b0;
			end
			irq_pkg::S_TAB_LO, irq_pkg::S_TAB_HI: begin
				addr_d = {vb_q, vec_d} + ((state_d == irq_pkg::S_TAB_HI) ? 16'h0001
					: 16'h0000); // RULE_08
				mem_n_d = 1'b0;
				rd_n_d = 1'b0;
			end
			default: begin
				if (fetch_strobe) begin
					addr_d = {vb_q, r_val}; // RULE_14
				end
			end
		endcase
	end

	always_comb begin
		rdata_d = 16'h0000;
		if (reg_sel < 5'h08) begin
			rdata_d = {8'h00, byte_of(vis, reg_sel[2:0])};
		end else if (reg_sel <= irq_pkg::SEL_PAIR3) begin
			rdata_d = pair_of(vis, 2'(reg_sel - 5'h07)); // RULE_15
		end else begin
			unique case (reg_sel)
				irq_pkg::SEL_VB: rdata_d = {8'h00, vb_q};
				irq_pkg::SEL_R:  rdata_d = {8'h00, r_val};
				irq_pkg::SEL_IX: rdata_d = ix_q;
				irq_pkg::SEL_IY: rdata_d = iy_q;
				irq_pkg::SEL_SP: rdata_d = sp_q;
				irq_pkg::SEL_PC: rdata_d = next_fetch_address_q;
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= irq_pkg::S_IDLE;
			entry_q <= irq_pkg::ENTRY_NMI;
			wcnt_q <= 2'h0;
			vec_q <= irq_pkg::R8_RESET;
			tlo_q <= irq_pkg::R8_RESET;
			sp_q <= irq_pkg::SP_RESET;
			ix_q <= irq_pkg::W16_RESET;
			iy_q <= irq_pkg::W16_RESET;
			vb_q <= irq_pkg::R8_RESET;
			nmi_seen_q <= 1'b0;
			nmi_pend_q <= 1'b0;
			next_fetch_address_q <= irq_pkg::PC_RESET;
			irq_enable_main_q <= 1'b0; // RULE_11
			irq_enable_saved_q <= 1'b0;
			irq_mode_bits_q <= irq_pkg::MODE0;
			reg_rdata_q <= irq_pkg::W16_RESET;
			address_q <= irq_pkg::W16_RESET;
			data_out_q <= irq_pkg::R8_RESET;
			memory_cycle_strobe_n_q <= 1'b1;
			io_cycle_strobe_n_q <= 1'b1;
			opcode_fetch_cycle_n_q <= 1'b1;
			read_n_q <= 1'b1;
			write_n_q <= 1'b1;
			ack_wait_q <= 1'b0;
			busy_q <= 1'b0;
			mode0_opcode_q <= irq_pkg::R8_RESET;
			mode0_valid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			entry_q <= entry_d;
			wcnt_q <= wcnt_d;
			vec_q <= vec_d;
			tlo_q <= tlo_d;
			sp_q <= sp_d;
			ix_q <= ix_d;
			iy_q <= iy_d;
			vb_q <= vb_d;
			nmi_seen_q <= nmi_req;
			nmi_pend_q <= nmi_pend_d;
			next_fetch_address_q <= pc_d;
			irq_enable_main_q <= irq_enable_main_d;
			irq_enable_saved_q <= irq_enable_saved_d;
			irq_mode_bits_q <= mode_d;
			reg_rdata_q <= rdata_d;
			address_q <= addr_d;
			data_out_q <= dout_d;
			memory_cycle_strobe_n_q <= mem_n_d;
			io_cycle_strobe_n_q <= io_n_d;
			opcode_fetch_cycle_n_q <= fetch_n_d;
			read_n_q <= rd_n_d;
			write_n_q <= wr_n_d;
			ack_wait_q <= state_d == irq_pkg::S_ACK_WAIT;
			busy_q <= state_d != irq_pkg::S_IDLE;
			mode0_opcode_q <= m0op_d;
			mode0_valid_q <= m0v_d;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_ack_waits;
		(state_q == irq_pkg::S_ACK_WAIT && ack_wait_q) [*2];
	endsequence
	sequence s_push;
		state_q == irq_pkg::S_PUSH_HI && !write_n_q ##1 state_q == irq_pkg::S_PUSH_LO;
	endsequence

	property p_nmi_vector;
		take_nmi |=> s_push ##1 state_q == irq_pkg::S_JUMP
			##1 next_fetch_address_q == irq_pkg::NMI_ADDR;
	endproperty
	a_nmi_vector: assert property (p_nmi_vector) else $error("nmi entry wrong"); // RULE_01

	property p_int_gate;
		state_q == irq_pkg::S_IDLE && instr_boundary && (bus_hold_request
			|| (!irq_enable_main_q && !nmi_pend_q)) |=> state_q == irq_pkg::S_IDLE;
	endproperty
	a_int_gate: assert property (p_int_gate) else $error("request taken wrongly"); // RULE_02

	property p_ack_strobes;
		state_q == irq_pkg::S_ACK |-> !io_cycle_strobe_n_q && memory_cycle_strobe_n_q
			&& !opcode_fetch_cycle_n_q;
	endproperty
	a_ack_strobes: assert property (p_ack_strobes) else $error("ack strobes wrong"); // RULE_03

	property p_ack_length;
		state_q == irq_pkg::S_ACK |=> s_ack_waits ##1 state_q == irq_pkg::S_ACK_TAKE;
	endproperty
	a_ack_length: assert property (p_ack_length) else $error("ack not two waits"); // RULE_04

	property p_mode2_ptr;
		state_q == irq_pkg::S_TAB_LO |-> address_q == {vb_q, vec_q} && !read_n_q;
	endproperty
	a_mode2_ptr: assert property (p_mode2_ptr) else $error("table pointer wrong"); // RULE_08

	property p_mode2_jump;
		state_q == irq_pkg::S_TAB_HI |=> next_fetch_address_q == {$past(data_in), tlo_q};
	endproperty
	a_mode2_jump: assert property (p_mode2_jump) else $error("table jump wrong"); // RULE_09

	property p_disable;
		op_ok && mask_off_op |=> !irq_enable_main_q && !irq_enable_saved_q;
	endproperty
	a_disable: assert property (p_disable) else $error("disable failed"); // RULE_11

	property p_copy_pv;
		op_ok && (copy_vector_base_op || copy_refresh_op) |=>
			vis[8*irq_pkg::IDX_F + irq_pkg::PV_BIT] == $past(irq_enable_saved_q)
			&& $stable(irq_enable_main_q) && $stable(irq_enable_saved_q);
	endproperty
	a_copy_pv: assert property (p_copy_pv) else $error("parity copy wrong"); // RULE_12

	property p_nmi_enables;
		take_nmi |=> !irq_enable_main_q && irq_enable_saved_q == $past(irq_enable_saved_q);
	endproperty
	a_nmi_enables: assert property (p_nmi_enables) else $error("nmi enables wrong"); // RULE_13

	property p_refresh_step;
		fetch_strobe && !r_load && state_q == irq_pkg::S_IDLE && !take_int |=>
			r_val == $past(r_val) + 8'h01;
	endproperty
	a_refresh_step: assert property (p_refresh_step) else $error("refresh not stepped"); // RULE_14
endmodule

// [verification/irq_peripheral.sv]
// Model of the interrupting peripheral and of the memory holding the vector table.
`timescale 1ns/1ps
module irq_peripheral (
	input  wire logic        clk_sys,
	input  wire logic        slow,
	input  wire logic [7:0]  ack_byte,
	input  wire logic [15:0] address_q,
	input  wire logic        memory_cycle_strobe_n_q,
	input  wire logic        io_cycle_strobe_n_q,
	input  wire logic        opcode_fetch_cycle_n_q,
	input  wire logic        read_n_q,
	output logic      [7:0]  data_in
);
	logic [2:0] cnt_q = 3'h0;
	logic       prev_q = 1'b0;
	logic [7:0] last_q = 8'h00;
	logic       ack_now;
	logic       win;
	function automatic logic [7:0] tbyte(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3c;
	endfunction
	assign ack_now = !io_cycle_strobe_n_q && !opcode_fetch_cycle_n_q;
	assign win = slow ? (cnt_q == 3'h3 || cnt_q == 3'h4) : (ack_now || cnt_q != 3'h0);
	always_ff @(posedge clk_sys) begin
		prev_q <= ack_now;
		last_q <= data_in;
		if (ack_now && !prev_q) begin
			cnt_q <= 3'h1;
		end else if (cnt_q != 3'h0 && cnt_q < 3'h4) begin
			cnt_q <= cnt_q + 3'h1;
		end else begin
			cnt_q <= 3'h0;
		end
	end
	// The bus shows a changing pattern whenever nobody answers.
	always_comb begin
		if (!memory_cycle_strobe_n_q && !read_n_q) begin
			data_in = tbyte(address_q);
		end else if (win) begin
			data_in = ack_byte;
		end else begin
			data_in = ~last_q;
		end
	end
endmodule

// [verification/tb_cpu_interrupt_response.sv]
// Self-checking bench for the interrupt response and register logic.
`timescale 1ns/1ps
module tb_cpu_interrupt_response;
	typedef struct {int kind; logic [15:0] v; logic [15:0] w; logic [15:0] a;} note_t;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        nmi_req = 1'b0, int_req = 1'b0, bus_hold_request = 1'b0, slow = 1'b0;
	logic        instr_boundary = 1'b0, fetch_strobe = 1'b0, mask_off_op = 1'b0;
	logic        unmask_op = 1'b0, nonmaskable_return_op = 1'b0, copy_vector_base_op = 1'b0;
	logic        copy_refresh_op = 1'b0, exchange_af_op = 1'b0, exchange_bank_op = 1'b0;
	logic        set_mode_op = 1'b0, reg_we = 1'b0, chk_req = 1'b0;
	logic [1:0]  set_mode_value = 2'h0, irq_mode_bits_q, m;
	logic [4:0]  reg_sel = 5'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata_q, address_q, next_fetch_address_q;
	logic [7:0]  data_in, ack_byte = 8'h00, data_out_q, mode0_opcode_q, vb, rfr;
	logic        memory_cycle_strobe_n_q, io_cycle_strobe_n_q, opcode_fetch_cycle_n_q;
	logic        read_n_q, write_n_q, ack_wait_q, busy_q, mode0_valid_q;
	logic        irq_enable_main_q, irq_enable_saved_q;
	logic [31:0] seed = 32'h9dbad428;
	logic [15:0] pc, sp, d, p, wa = 16'h0000, wd = 16'h0000;
	logic        busy_p = 1'b0, io_p = 1'b1, pc_due = 1'b0;
	logic [4:0]  sels [6] = '{irq_pkg::SEL_VB, irq_pkg::SEL_R, irq_pkg::SEL_IX,
		irq_pkg::SEL_IY, irq_pkg::SEL_SP, irq_pkg::SEL_PC};
	logic [15:0] vals [6];
	int          fails = 0, checked = 0, wc = 0, ac = 0, nw = 0;
	note_t       q[$];
	note_t       n;
	cpu_interrupt_response u_cpu_interrupt_response (.clk_sys, .sys_rst, .nmi_req, .int_req,
		.bus_hold_request, .data_in, .instr_boundary, .fetch_strobe, .mask_off_op, .unmask_op,
		.nonmaskable_return_op, .copy_vector_base_op, .copy_refresh_op, .exchange_af_op,
		.exchange_bank_op, .set_mode_op, .set_mode_value, .reg_we, .reg_sel, .reg_wdata,
		.reg_rdata_q, .address_q, .data_out_q, .memory_cycle_strobe_n_q, .io_cycle_strobe_n_q,
		.opcode_fetch_cycle_n_q, .read_n_q, .write_n_q, .ack_wait_q, .busy_q, .mode0_opcode_q,
		.mode0_valid_q, .irq_enable_main_q, .irq_enable_saved_q, .irq_mode_bits_q,
		.next_fetch_address_q);
	irq_peripheral u_irq_peripheral (.clk_sys, .slow, .ack_byte, .address_q,
		.memory_cycle_strobe_n_q, .io_cycle_strobe_n_q, .opcode_fetch_cycle_n_q, .read_n_q,
		.data_in);
	always #4 clk_sys = ~clk_sys;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] tbyte(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3c;
	endfunction
	task automatic tick(input int c);
		repeat (c) @(negedge clk_sys);
	endtask
	task automatic wr(input logic [4:0] s, input logic [15:0] v);
		reg_we = 1'b1;
		reg_sel = s;
		reg_wdata = v;
		tick(1);
		reg_we = 1'b0;
		tick(1);
	endtask
	task automatic probe(input int k, input logic [15:0] e, input logic b = 0, input logic f = 0);
		q.push_back('{k, e, 16'h0000, 16'h0000});
		instr_boundary = b;
		fetch_strobe = f;
		chk_req = 1'b1;
		tick(1);
		instr_boundary = 1'b0;
		fetch_strobe = 1'b0;
		chk_req = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [4:0] s, input logic [15:0] e, input int k = 0);
		reg_sel = s;
		probe(k, e);
	endtask
	task automatic pulse(ref logic x);
		x = 1'b1;
		tick(1);
		x = 1'b0;
		tick(1);
	endtask
	task automatic enter(input int k, input logic push, input logic [15:0] npc);
		q.push_back('{k, npc, push ? pc : 16'h0000, push ? sp - 16'h0001 : 16'h0000});
		if (push) begin
			sp = sp - 16'h0002;
		end
		pc = npc;
		instr_boundary = 1'b1;
		tick(1);
		instr_boundary = 1'b0;
		for (int i = 0; i < 40 && busy_q !== 1'b0; i++) begin
			tick(1);
		end
		tick(3);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Watches the outputs and settles each note in the order it was queued.
	always @(posedge clk_sys) begin
		#2;
		if (io_p && !io_cycle_strobe_n_q && !opcode_fetch_cycle_n_q && memory_cycle_strobe_n_q) begin
			ac++;
		end
		io_p = io_cycle_strobe_n_q;
		if (ack_wait_q === 1'b1) begin
			wc++;
		end
		if (!memory_cycle_strobe_n_q && !write_n_q) begin
			wa = (nw == 0) ? address_q : wa;
			wd = {wd[7:0], data_out_q};
			nw++;
		end
		if (chk_req) begin
			n = q.pop_front();
			case (n.kind)
				0: check(reg_rdata_q, n.v);
				3: check({11'h000, busy_q, irq_enable_main_q, irq_enable_saved_q,
					irq_mode_bits_q}, n.v);
				5: check(16'(reg_rdata_q[irq_pkg::PV_BIT]), n.v);
				default: check({8'h00, address_q[15:8]}, n.v);
			endcase
		end
		if (mode0_valid_q === 1'b1) begin
			n = q.pop_front();
			check({8'h00, mode0_opcode_q}, n.v);
		end
		if (pc_due) begin
			n = q.pop_front();
			check(next_fetch_address_q, n.v);
			check(wd, n.w);
			check(wa, n.a);
			check(16'(wc * 16 + ac), 16'(n.kind));
			wc = 0;
			ac = 0;
			nw = 0;
			{wa, wd} = 32'h0;
		end
		pc_due = busy_p && busy_q === 1'b0;
		busy_p = busy_q;
	end
	initial begin
		#100000;
		fails++;
		wrap_up();
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		tick(1);
		sys_rst = 1'b0;
		probe(3, 16'h0000);
		rd(irq_pkg::SEL_PC, irq_pkg::PC_RESET);
		rd(irq_pkg::SEL_SP, irq_pkg::SP_RESET);
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			d = 16'(rnd());
			wr(irq_pkg::SEL_PAIR1 + 5'(i), d);
			rd(5'(2 * i + 2), {8'h00, d[15:8]});
			rd(5'(2 * i + 3), {8'h00, d[7:0]});
		end
		foreach (sels[i]) begin
			vals[i] = 16'(rnd());
			wr(sels[i], vals[i]);
			rd(sels[i], i < 2 ? {8'h00, vals[i][7:0]} : vals[i]);
		end
		rd(5'h1f, 16'h0000);
		{vb, rfr, sp, pc} = {vals[0][7:0], vals[1][7:0], vals[4], vals[5]};
		wr(5'(irq_pkg::IDX_A), {8'h00, d[7:0]});
		pulse(exchange_af_op);
		rd(5'(irq_pkg::IDX_A), 16'h0000);
		pulse(exchange_af_op);
		rd(5'(irq_pkg::IDX_A), {8'h00, d[7:0]});
		pulse(exchange_bank_op);
		rd(5'h06, 16'h0000);
		pulse(exchange_bank_op);
		rd(5'h06, {8'h00, d[15:8]});
		$display("test registers done");
		pulse(unmask_op);
		probe(3, 16'h000c);
		pulse(copy_vector_base_op);
		rd(5'(irq_pkg::IDX_A), {8'h00, vb});
		rd(5'(irq_pkg::IDX_F), 16'h0001, 5);
		pulse(mask_off_op);
		probe(3, 16'h0000);
		pulse(copy_refresh_op);
		rd(5'(irq_pkg::IDX_A), {8'h00, rfr});
		rd(5'(irq_pkg::IDX_F), 16'h0000, 5);
		for (int i = 0; i < 4; i++) begin
			probe(4, {8'h00, vb}, 1'b0, 1'b1);
		end
		rd(irq_pkg::SEL_R, {8'h00, rfr + 8'h04});
		$display("test enables and refresh done");
		pulse(unmask_op);
		nmi_req = 1'b1;
		bus_hold_request = 1'b1;
		tick(1);
		probe(3, 16'h000c, 1'b1);
		bus_hold_request = 1'b0;
		enter(0, 1'b1, irq_pkg::NMI_ADDR);
		nmi_req = 1'b0;
		probe(3, 16'h0004);
		pulse(nonmaskable_return_op);
		probe(3, 16'h000c);
		pulse(mask_off_op);
		int_req = 1'b1;
		probe(3, 16'h0000, 1'b1);
		pulse(unmask_op);
		bus_hold_request = 1'b1;
		probe(3, 16'h000c, 1'b1);
		bus_hold_request = 1'b0;
		$display("test nonmaskable and refusal done");
		for (int k = 0; k < 6; k++) begin
			m = 2'(k % 3);
			slow = k > 2;
			pulse(unmask_op);
			set_mode_value = m;
			pulse(set_mode_op);
			probe(3, {12'h000, 2'b11, m});
			d = 16'(rnd());
			ack_byte = (m == irq_pkg::MODE2) ? d[7:0] & 8'hfe : d[7:0];
			p = {vb, ack_byte};
			if (m == irq_pkg::MODE0) begin
				q.push_back('{0, {8'h00, ack_byte}, 16'h0000, 16'h0000});
				enter(33, 1'b0, pc);
			end else begin
				enter(33, 1'b1, m == irq_pkg::MODE1 ? irq_pkg::MODE1_ADDR
					: {tbyte(p + 16'h0001), tbyte(p)});
			end
			probe(3, {14'h0000, m});
			$display("test mode %0d done", m);
		end
		wrap_up();
	end
endmodule
